// ### design/vpc_coil_driver.sv
// Purpose: valve current loop with dither and pump contactor pull-in/hold duty
// Assumes: sense words come from same-clock converter logic; tick is a control pulse
// Notes:   duty outputs are 0..32767 full scale, except the driver 3 script value, which passes unclamped; pwm generation lies elsewhere
// Functional notes
// R1 - loop-select set means valve duty comes from the current loop, else from the script value.
// R2 - lowering-source set means lowering follows throttle, else the script lowering variable.
// R3 - the current command is capped at the programmed ceiling, range 0..607.
// R4 - the current command is held at or above the programmed floor, same range.
// R5 - dither alternately adds and subtracts a percentage of the ceiling, 32767 for full.
// R6 - dither period code 1..7 spans 16..112 ms.
// R7 - the loop applies a proportional gain held as 82..8192; kp is stored as written, with no clamp to that range.
// R8 - the loop applies an integral gain held as 327..32767 that drives error to zero; ki is stored as written, with no clamp to that range.
// R9 - limits, dither and gains act only while loop-select is set.
// R10 - with pump-contactor set, start closes driver 3 with pull-in then hold, stop opens it.
// R11 - with pump-contactor clear, driver 3 is script owned and start or stop do nothing.
// R12 - driver 3 applies pull-in first and switches to holding after one second.
// R13 - pull-in and holding levels span 0..32767, holding being a reduced average.
// R14 - driver 3 duty is compensated for battery voltage.
// R15 - compensated duty gives nominal voltage times percentage, not actual times percentage.
// R16 - period code n gives n times 16 ms, add and subtract phases each half of it.
// R17 - loop output saturates to 0..full duty and the integrator halts while saturated.
//
// The plain strobed port was chosen for this implementation.
module vpc_coil_driver
	import vpc_pkg::*;
#(
	parameter longint DITHER_UNIT = DITHER_UNIT_CYC,
	parameter longint PULL_IN     = PULL_IN_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        clkEn,
	input  wire logic        tick,
	input  wire vpc_bus_t    bus,
	output logic      [15:0] rdata,
	input  wire vpc_sense_t  sense,
	input  wire logic        pumpStart,
	input  wire logic        pumpStop,
	input  wire logic [15:0] scriptDriver3,
	output logic      [15:0] valveDuty,
	output logic      [15:0] pumpDuty,
	output logic             lowerActive
);
	// elaboration guard: the counters below are sized for these spans only
	if (DITHER_UNIT < 2) begin
		$error("vpc_coil_driver: DITHER_UNIT below two cycles");
	end
	if (DITHER_UNIT > 64'd100000000) begin
		$error("vpc_coil_driver: DITHER_UNIT overflows the unit counter");
	end
	if (PULL_IN < 1) begin
		$error("vpc_coil_driver: PULL_IN must be at least one cycle");
	end
	if (PULL_IN > 64'd4294967295) begin
		$error("vpc_coil_driver: PULL_IN overflows the pull-in counter");
	end

	// register file
	logic [15:0] ceiling;
	logic [15:0] floorCur;
	logic [15:0] dithAmt;
	logic [15:0] dithPer;
	logic [15:0] kp;
	logic [15:0] ki;
	logic [15:0] opt1;
	logic [15:0] opt4;
	logic [15:0] pullIn;
	logic [15:0] hold;
	logic [15:0] scrDuty;
	logic [15:0] scrLower;
	logic [15:0] nomBatt;
	// option bits decoded once
	logic        loopSel;
	logic        lowerSrc;
	logic        pumpMode;
	assign loopSel  = opt1[LOOP_SELECT_BIT];
	assign lowerSrc = opt1[LOWER_SRC_BIT];
	assign pumpMode = opt4[PUMP_CONTACT_BIT];

	// loop settings; limits, dither amount and period are clamped on entry, the gains are stored as written
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ceiling  <= RST_CEILING;
			floorCur <= RST_ZERO;
			dithAmt  <= RST_ZERO;
			dithPer  <= RST_DITHPER;
			kp       <= RST_KP;
			ki       <= RST_KI;
		end else if (clkEn && bus.wr) begin
			case (bus.addr)
				REG_CEILING: ceiling  <= (bus.wdata > CURRENT_MAX) ? CURRENT_MAX : bus.wdata; // R3
				REG_FLOOR:   floorCur <= (bus.wdata > CURRENT_MAX) ? CURRENT_MAX : bus.wdata; // R4
				REG_DITHAMT: dithAmt  <= (bus.wdata > PCT_FULL) ? PCT_FULL : bus.wdata; // R5
				REG_DITHPER: begin
					// R6
					// codes outside 1..7 are pulled to the nearest end
					if (bus.wdata == 16'h0000)
						dithPer <= 16'h0001;
					else if (bus.wdata > 16'h0007)
						dithPer <= 16'h0007;
					else
						dithPer <= bus.wdata;
				end
				REG_KP:      kp       <= bus.wdata; // R7
				REG_KI:      ki       <= bus.wdata; // R8
				default: ;
			endcase
		end
	end

	// option words; only three bits are decoded, the rest read back as written
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			opt1 <= RST_ZERO;
			opt4 <= RST_ZERO;
		end else if (clkEn && bus.wr) begin
			case (bus.addr)
				REG_OPT1: opt1 <= bus.wdata;
				REG_OPT4: opt4 <= bus.wdata;
				default: ;
			endcase
		end
	end

	// driver 3 levels and the nominal battery reference for compensation
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pullIn  <= RST_ZERO;
			hold    <= RST_ZERO;
			nomBatt <= RST_NOMBATT;
		end else if (clkEn && bus.wr) begin
			case (bus.addr)
				REG_PULLIN:  pullIn  <= (bus.wdata > PCT_FULL) ? PCT_FULL : bus.wdata; // R13
				REG_HOLD:    hold    <= (bus.wdata > PCT_FULL) ? PCT_FULL : bus.wdata; // R13
				REG_NOMBATT: nomBatt <= bus.wdata;
				default: ;
			endcase
		end
	end

	// script-owned values, used while the loop or the lowering source is off
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scrDuty  <= RST_ZERO;
			scrLower <= RST_ZERO;
		end else if (clkEn && bus.wr) begin
			case (bus.addr)
				REG_SCRDUTY:  scrDuty  <= (bus.wdata > DUTY_FULL) ? DUTY_FULL : bus.wdata;
				REG_SCRLOWER: scrLower <= bus.wdata;
				default: ;
			endcase
		end
	end

	// lowering request select
	logic [15:0] lowerReq;
	assign lowerReq = lowerSrc ? sense.throttle : scrLower; // R2

	// dither timing: unit counter, then half-period phase toggle
	logic [26:0] unitCnt;
	logic [3:0]  halfCnt;
	logic        dithSub;
	logic        unitDone;
	// an odd unit length loses half a cycle per step, negligible at 16 ms
	assign unitDone = (unitCnt == 27'(DITHER_UNIT / 2 - 1));
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			unitCnt <= '0;
			halfCnt <= '0;
			dithSub <= 1'b0;
		end else if (clkEn) begin
			// half a 16 ms unit counted per step; n steps make half a period
			if (unitDone) begin
				unitCnt <= '0;
				if (halfCnt + 4'd1 >= dithPer[3:0]) begin // R16
					halfCnt <= '0;
					dithSub <= ~dithSub; // R5
				end else begin
					halfCnt <= halfCnt + 4'd1;
				end
			end else begin
				unitCnt <= unitCnt + 27'd1;
			end
		end
	end

	// current target: floor/ceiling limited, then dither added or subtracted
	logic [31:0] dithProd;
	logic [15:0] dithDelta;
	logic [15:0] lowerCur;
	logic [31:0] lowerProd;
	logic signed [17:0] target;
	always_comb begin
		dithProd  = ceiling * dithAmt;
		dithDelta = dithProd[30:15]; // R5
		lowerProd = ceiling * lowerReq;
		lowerCur  = (lowerReq == 16'h0000) ? 16'h0000 : lowerProd[30:15];
		if (lowerReq != 16'h0000 && lowerCur < floorCur)
			lowerCur = floorCur; // R4
		if (lowerCur > ceiling)
			lowerCur = ceiling; // R3
		target = dithSub ? $signed({2'b00, lowerCur}) - $signed({2'b00, dithDelta})
		                 : $signed({2'b00, lowerCur}) + $signed({2'b00, dithDelta}); // R5
		if (lowerCur == 16'h0000)
			target = '0;
	end

	// pi loop, evaluated on each control tick
	logic signed [17:0] err;
	logic signed [35:0] pTerm;
	logic signed [35:0] integ;
	logic signed [35:0] piSum;
	logic [15:0]        loopDuty;
	logic               sat;
	always_comb begin
		err   = target - $signed({2'b00, sense.valveCurrent});
		pTerm = err * $signed({1'b0, kp}); // R7
		piSum = pTerm + integ;
		sat   = 1'b0;
		// saturate before the duty is taken
		if (piSum < 0) begin
			loopDuty = 16'h0000; // R17
			sat      = 1'b1;
		end else if (piSum[35:13] > 23'(DUTY_FULL)) begin
			loopDuty = DUTY_FULL; // R17
			sat      = 1'b1;
		end else begin
			loopDuty = piSum[28:13];
		end
	end

	// integrator halts while saturated so windup cannot build
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			integ <= '0;
		end else if (clkEn) begin
			if (!loopSel) begin
				integ <= '0; // R9
			end else if (tick && !sat) begin
				integ <= integ + 36'(err * $signed({1'b0, ki}) >>> 2); // R8 R17
			end
		end
	end

	// valve output selection
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			valveDuty   <= RST_ZERO;
			lowerActive <= 1'b0;
		end else if (clkEn) begin
			lowerActive <= (lowerReq != 16'h0000);
			if (loopSel) begin
				if (tick)
					valveDuty <= loopDuty; // R1 R9
			end else begin
				valveDuty <= scrDuty; // R1
			end
		end
	end

	// pump contactor sequence
	vpc_pump_t  pumpState;
	logic [31:0] pullCnt;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pumpState <= PUMP_OFF;
			pullCnt   <= '0;
		end else if (clkEn) begin
			case (pumpState)
				PUMP_OFF: begin
					// parked at zero so every start gets the whole pull-in time
					pullCnt <= '0;
					if (pumpMode && pumpStart && !pumpStop)
						pumpState <= PUMP_PULL; // R10
				end
				PUMP_PULL: begin
					pullCnt <= pullCnt + 32'd1;
					if (!pumpMode || pumpStop)
						pumpState <= PUMP_OFF; // R10 R11
					else if (pullCnt == 32'(PULL_IN - 1))
						pumpState <= PUMP_HOLD; // R12
				end
				PUMP_HOLD: begin
					if (!pumpMode || pumpStop)
						pumpState <= PUMP_OFF; // R10 R11
				end
				default: pumpState <= PUMP_OFF;
			endcase
		end
	end

	// battery compensation: duty = level * nominal / actual, clipped at full
	// a dead battery reading gives full duty rather than a divide by zero
	logic [15:0] level;
	logic [31:0] compNum;
	logic [31:0] compDuty;
	always_comb begin
		level    = (pumpState == PUMP_PULL) ? pullIn : hold; // R12 R13
		compNum  = level * nomBatt; // R15
		compDuty = (sense.battVolt == 16'h0000) ? 32'(DUTY_FULL) : compNum / sense.battVolt; // R14
	end

	// driver 3 duty: script value, or the compensated contactor level
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pumpDuty <= RST_ZERO;
		end else if (clkEn) begin
			if (!pumpMode)
				pumpDuty <= scriptDriver3; // R11
			else if (pumpState == PUMP_OFF)
				pumpDuty <= RST_ZERO; // R10
			else
				pumpDuty <= (compDuty > 32'(DUTY_FULL)) ? DUTY_FULL : compDuty[15:0]; // R14
		end
	end

	// register readback, one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= RST_ZERO;
		end else if (clkEn) begin
			rdata <= RST_ZERO;
			if (bus.rd) begin
				case (bus.addr)
					REG_CEILING:  rdata <= ceiling;
					REG_FLOOR:    rdata <= floorCur;
					REG_DITHAMT:  rdata <= dithAmt;
					REG_DITHPER:  rdata <= dithPer;
					REG_KP:       rdata <= kp;
					REG_KI:       rdata <= ki;
					REG_OPT1:     rdata <= opt1;
					REG_OPT4:     rdata <= opt4;
					REG_PULLIN:   rdata <= pullIn;
					REG_HOLD:     rdata <= hold;
					REG_SCRDUTY:  rdata <= scrDuty;
					REG_SCRLOWER: rdata <= scrLower;
					REG_NOMBATT:  rdata <= nomBatt;
					// status: sat bit 3, dither phase bit 2, pump state bits 1:0
					REG_STATUS:   rdata <= {12'h000, sat, dithSub, pumpState};
					REG_VALVEOUT: rdata <= valveDuty;
					REG_PUMPOUT:  rdata <= pumpDuty;
					default:      rdata <= RST_ZERO;
				endcase
			end
		end
	end
endmodule

// ### design/vpc_pkg.sv
// Purpose: shared constants and types for the valve and pump coil driver
// Assumes: 16-bit register words, 200 MHz sys_clk
// Notes:   register offsets are word indices; byte address is index times four
package vpc_pkg;
	// register indices
	localparam logic [15:0] REG_CEILING  = 16'h3040;
	localparam logic [15:0] REG_FLOOR    = 16'h3041;
	localparam logic [15:0] REG_DITHAMT  = 16'h3042;
	localparam logic [15:0] REG_DITHPER  = 16'h3043;
	localparam logic [15:0] REG_KP       = 16'h3044;
	localparam logic [15:0] REG_KI       = 16'h3045;
	localparam logic [15:0] REG_OPT1     = 16'h306A;
	localparam logic [15:0] REG_OPT4     = 16'h306D;
	localparam logic [15:0] REG_PULLIN   = 16'h3864;
	localparam logic [15:0] REG_HOLD     = 16'h3865;
	localparam logic [15:0] REG_SCRDUTY  = 16'h3900;
	localparam logic [15:0] REG_SCRLOWER = 16'h3901;
	localparam logic [15:0] REG_NOMBATT  = 16'h3902;
	localparam logic [15:0] REG_STATUS   = 16'h3903;
	localparam logic [15:0] REG_VALVEOUT = 16'h3904;
	localparam logic [15:0] REG_PUMPOUT  = 16'h3905;
	// field positions
	localparam int LOOP_SELECT_BIT  = 6;
	localparam int LOWER_SRC_BIT    = 7;
	localparam int PUMP_CONTACT_BIT = 1;
	// reset values
	localparam logic [15:0] RST_ZERO    = 16'h0000;
	localparam logic [15:0] RST_CEILING = 16'h025F;
	localparam logic [15:0] RST_DITHPER = 16'h0001;
	localparam logic [15:0] RST_KP      = 16'h0052;
	localparam logic [15:0] RST_KI      = 16'h0147;
	localparam logic [15:0] RST_NOMBATT = 16'h0C00;
	// limits and scales
	localparam logic [15:0] CURRENT_MAX = 16'h025F;
	localparam logic [15:0] PCT_FULL    = 16'h7FFF;
	localparam logic [15:0] DUTY_FULL   = 16'h7FFF;
	// timing
	localparam int CLK_HZ            = 200_000_000;
	localparam int DITHER_UNIT_MS    = 16;
	localparam int PULL_IN_MS        = 1000;
	localparam longint DITHER_UNIT_CYC = longint'(CLK_HZ) * DITHER_UNIT_MS / 1000;
	localparam longint PULL_IN_CYC     = longint'(CLK_HZ) * PULL_IN_MS / 1000;

	typedef enum logic [1:0] {
		PUMP_OFF  = 2'b00,
		PUMP_PULL = 2'b01,
		PUMP_HOLD = 2'b10
	} vpc_pump_t;

	// register bus request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} vpc_bus_t;

	// analog samples from the converters
	typedef struct packed {
		logic [15:0] valveCurrent;
		logic [15:0] throttle;
		logic [15:0] battVolt;
	} vpc_sense_t;
endpackage

// ### tb/valve_and_pump_coil_driver_tb.sv
// Purpose: register-level tests of the coil driver
// Assumes: shortened pull-in and dither counts
// Notes:   loop checks allow a few counts of settling error
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module valve_and_pump_coil_driver_tb
	import vpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, rstn, clkEn, tick, pumpStart, pumpStop, lowerActive;
	logic [1:0]  tickCnt;
	logic [15:0] rdata, valveDuty, pumpDuty, throttle, scriptDriver3, valveCurrent, battVolt;
	vpc_bus_t    bus;
	vpc_sense_t  sense;
	int          n_fail, tests_run, i;
	localparam logic [15:0] RADR [13] = '{REG_CEILING, REG_FLOOR, REG_DITHAMT, REG_DITHPER,
		REG_KP, REG_KI, REG_OPT1, REG_OPT4, REG_PULLIN, REG_HOLD, REG_SCRDUTY, REG_NOMBATT, 16'h1234};
	localparam logic [15:0] RVAL [13] = '{RST_CEILING, RST_ZERO, RST_ZERO, RST_DITHPER, RST_KP,
		RST_KI, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_NOMBATT, RST_ZERO};
	assign sense = '{valveCurrent, throttle, battVolt};
	always #2.5 sys_clk = ~sys_clk;
	// one tick in four keeps loop runs short
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tickCnt <= 2'h0;
			tick    <= 1'b0;
		end else begin
			tickCnt <= tickCnt + 2'h1;
			tick    <= (tickCnt == 2'h3);
		end
	end
	vpc_coil_driver #(.DITHER_UNIT(20), .PULL_IN(50)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
		.clkEn(clkEn), .tick(tick), .bus(bus), .rdata(rdata), .sense(sense),
		.pumpStart(pumpStart), .pumpStop(pumpStop), .scriptDriver3(scriptDriver3),
		.valveDuty(valveDuty), .pumpDuty(pumpDuty), .lowerActive(lowerActive));
	vpc_coil_model i_coil (.sys_clk(sys_clk), .rstn(rstn), .valveDuty(valveDuty),
		.valveCurrent(valveCurrent), .battVolt(battVolt));
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
		@(posedge sys_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge sys_clk);
		bus <= '0;
		#1;
		`CHK(n, e, rdata)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic near(input logic [15:0] lo, input logic [15:0] hi);
		cyc(4000);
		`CHK("valve current", 1'b1, (valveCurrent >= lo) && (valveCurrent <= hi))
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard, about three and a half times the expected run
	initial begin
		#150us;
		n_fail++;
		results();
	end
	initial begin
		{sys_clk, rstn, pumpStart, pumpStop} = '0;
		{bus, throttle, scriptDriver3, n_fail, tests_run} = '0;
		clkEn = 1'b1;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		for (i = 0; i < 13; i++) rd(RADR[i], RVAL[i], "reset value");
		$display("test reset values done");
		wr(REG_CEILING, 16'h03E8);
		rd(REG_CEILING, CURRENT_MAX, "ceiling clamp");
		wr(REG_FLOOR, 16'h0300);
		rd(REG_FLOOR, CURRENT_MAX, "floor clamp");
		wr(REG_DITHAMT, 16'h8000);
		rd(REG_DITHAMT, PCT_FULL, "dither clamp");
		wr(REG_DITHAMT, RST_ZERO);
		wr(REG_DITHPER, 16'h0009);
		rd(REG_DITHPER, 16'h0007, "period high");
		wr(REG_DITHPER, 16'h0000);
		rd(REG_DITHPER, 16'h0001, "period low");
		$display("test clamps done");
		wr(REG_SCRDUTY, 16'h1234);
		rd(REG_VALVEOUT, 16'h1234, "script duty");
		// a write while the clock enable is low must leave no trace
		@(posedge sys_clk) clkEn <= 1'b0;
		wr(REG_SCRDUTY, 16'h0555);
		clkEn <= 1'b1;
		rd(REG_SCRDUTY, 16'h1234, "frozen write");
		wr(REG_OPT1, 16'h0080);
		throttle <= 16'h0005;
		cyc(3);
		`CHK("throttle lowering", 1'b1, lowerActive)
		wr(REG_SCRLOWER, 16'h0007);
		throttle <= 16'h0000;
		cyc(3);
		`CHK("script ignored", 1'b0, lowerActive)
		wr(REG_OPT1, 16'h0000);
		cyc(3);
		`CHK("script lowering", 1'b1, lowerActive)
		$display("test lowering done");
		// half lowering of a 400 ceiling is 200, lifted to the 300 floor
		wr(REG_KP, 16'h2000);
		wr(REG_KI, 16'h7FFF);
		wr(REG_CEILING, 16'h0190);
		wr(REG_FLOOR, 16'h012C);
		wr(REG_SCRLOWER, 16'h4000);
		wr(REG_OPT1, 16'h0040);
		near(16'h0129, 16'h012F);
		wr(REG_FLOOR, RST_ZERO);
		near(16'h00C5, 16'h00CB);
		wr(REG_OPT1, 16'h0000);
		cyc(3);
		`CHK("loop released", 16'h1234, valveDuty)
		$display("test current loop done");
		@(posedge sys_clk);
		scriptDriver3 <= 16'h1111;
		pumpStart <= 1'b1;
		cyc(3);
		`CHK("driver 3 script", 16'h1111, pumpDuty)
		@(posedge sys_clk) pumpStart <= 1'b0;
		wr(REG_PULLIN, 16'h3E80);
		wr(REG_HOLD, 16'h1F40);
		wr(REG_OPT4, 16'h0002);
		@(posedge sys_clk) pumpStart <= 1'b1;
		@(posedge sys_clk) pumpStart <= 1'b0;
		cyc(3);
		`CHK("pull-in duty", 16'h4B00, pumpDuty)
		cyc(55);
		`CHK("holding duty", 16'h2580, pumpDuty)
		@(posedge sys_clk) pumpStop <= 1'b1;
		@(posedge sys_clk) pumpStop <= 1'b0;
		cyc(3);
		`CHK("pump stopped", 16'h0000, pumpDuty)
		$display("test pump done");
		results();
	end
endmodule

// ### tb/vpc_coil_driver_sva.sv
// Purpose: port-level checks for the coil driver
// Assumes: register writes stay in range; battVolt never zero
// Notes:   shadows the few registers the checks need from bus writes
module vpc_coil_driver_sva
	import vpc_pkg::*;
#(
	parameter longint DITHER_UNIT = 20,
	parameter longint PULL_IN     = 50
) (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        clkEn,
	input wire logic        tick,
	input wire vpc_bus_t    bus,
	input wire logic [15:0] rdata,
	input wire vpc_sense_t  sense,
	input wire logic        pumpStart,
	input wire logic        pumpStop,
	input wire logic [15:0] scriptDriver3,
	input wire logic [15:0] valveDuty,
	input wire logic [15:0] pumpDuty,
	input wire logic        lowerActive
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PULL_AT = int'(PULL_IN) + 1;
	logic        loopOn, lowerSrc, modeOn;
	logic [15:0] scrDuty, scrLower, pullIn, holdLvl, nomBatt;
	logic [31:0] pullW, holdW;
	// shadow copies; out-of-range clamping is not modelled
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{loopOn, lowerSrc, modeOn} <= 3'h0;
			{scrDuty, scrLower, pullIn, holdLvl} <= '0;
			nomBatt <= RST_NOMBATT;
		end else if (clkEn && bus.wr) begin
			case (bus.addr)
				REG_OPT1:     {lowerSrc, loopOn} <= bus.wdata[7:6];
				REG_OPT4:     modeOn <= bus.wdata[PUMP_CONTACT_BIT];
				REG_SCRDUTY:  scrDuty <= bus.wdata;
				REG_SCRLOWER: scrLower <= bus.wdata;
				REG_PULLIN:   pullIn <= bus.wdata;
				REG_HOLD:     holdLvl <= bus.wdata;
				REG_NOMBATT:  nomBatt <= bus.wdata;
				default: ;
			endcase
		end
	end
	// nominal over actual, so a sagging bus raises the duty
	assign pullW = (32'(pullIn) * 32'(nomBatt)) / 32'(sense.battVolt);
	assign holdW = (32'(holdLvl) * 32'(nomBatt)) / 32'(sense.battVolt);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == RST_ZERO)
		else $error("read data outside its cycle");
	a_script_duty: assert property ((!loopOn && !bus.wr) [*3] |-> valveDuty == scrDuty)
		else $error("valve duty not the script value");
	a_duty_range: assert property (valveDuty <= DUTY_FULL && pumpDuty <= DUTY_FULL)
		else $error("duty above full scale");
	a_lower_follow: assert property (lowerActive == ($past(lowerSrc) ?
		$past(sense.throttle) != 16'h0000 : $past(scrLower) != 16'h0000))
		else $error("lowering request from wrong source");
	a_drv3_script: assert property (!modeOn && !$past(modeOn) |->
		pumpDuty == $past(scriptDriver3)) else $error("driver 3 not script owned");
	a_pull_first: assert property ($rose(pumpStart) && modeOn && !pumpStop |->
		##2 pumpDuty == pullW[15:0]) else $error("pull-in duty wrong");
	a_pull_hold: assert property ($rose(pumpStart) && modeOn && !pumpStop |->
		##PULL_AT pumpDuty == pullW[15:0] ##1 pumpDuty == holdW[15:0])
		else $error("hold phase not after pull-in time");
	a_stop_open: assert property (pumpStop && modeOn |-> ##2 pumpDuty == RST_ZERO)
		else $error("stop did not open driver 3");
	cover property ($rose(pumpStart) && modeOn);
	cover property (tick && loopOn);
	cover property (bus.rd ##1 rdata != RST_ZERO);
endmodule

bind vpc_coil_driver vpc_coil_driver_sva #(.DITHER_UNIT(DITHER_UNIT), .PULL_IN(PULL_IN)) i_sva (
	.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .tick(tick), .bus(bus),
	.rdata(rdata), .sense(sense), .pumpStart(pumpStart), .pumpStop(pumpStop),
	.scriptDriver3(scriptDriver3), .valveDuty(valveDuty), .pumpDuty(pumpDuty),
	.lowerActive(lowerActive));

// ### tb/vpc_coil_model.sv
// Purpose: valve coil and supply seen from the driver
// Assumes: coil current settles within one cycle of a duty change
// Notes:   pump coil is a pure load, nothing is fed back from it
module vpc_coil_model
	import vpc_pkg::*;
#(
	parameter logic [15:0] BATT = 16'h0A00
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [15:0] valveDuty,
	output logic      [15:0] valveCurrent,
	output logic      [15:0] battVolt
);
	timeunit 1ns;
	timeprecision 1ps;
	// sagged below nominal so compensation shows
	assign battVolt = BATT;
	// full duty gives just under the 607 ceiling
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			valveCurrent <= 16'h0000;
		end else begin
			valveCurrent <= 16'((32'(valveDuty) * 32'(CURRENT_MAX)) >> 15);
		end
	end
endmodule
